// >>> hdl/clear_complement_pkg.sv
// Package: encodings, field positions, status layout and register offsets
package clear_complement_pkg;
    localparam logic [6:0] CLEAR_OPCODE = 7'h35;
    localparam logic [5:0] INVERT_OPCODE = 6'h07;
    localparam logic [15:0] WATCHDOG_WORD = 16'h0004;
    localparam int OP7_LSB = 9;
    localparam int OP6_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam int ACCESS_SPLIT = 8'h80;
    localparam int STATUS_N = 4;
    localparam int STATUS_Z = 2;
    localparam int STATUS_PD = 0;
    localparam int STATUS_TO = 1;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h03;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    // APB register byte offsets
    localparam logic [11:0] OFF_INSTR = 12'h000;
    localparam logic [11:0] OFF_WORKING = 12'h004;
    localparam logic [11:0] OFF_BANK = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_WATCHDOG = 12'h010;
    localparam logic [11:0] OFF_MEM_ADDR = 12'h014;
    localparam logic [11:0] OFF_MEM_DATA = 12'h018;
    localparam logic [11:0] OFF_COUNT = 12'h01c;

    typedef struct packed {
        logic do_clear;
        logic do_invert;
        logic do_watchdog;
        logic to_working;
        logic [11:0] address;
    } decode_type;
endpackage : clear_complement_pkg

// >>> hdl/instr_decode.sv
// Instruction word decoder for clear, invert and watchdog restart
`timescale 1ns/1ps
`default_nettype none
module instr_decode
    import clear_complement_pkg::*;
(
    input wire logic [15:0] word,
    input wire logic [7:0] bank_select_register,
    output decode_type dec
);
    logic [3:0] bank;

    always_comb
    begin
        if (word[ACCESS_BIT])
            bank = bank_select_register[3:0];
        else if (word[7:0] >= 8'(ACCESS_SPLIT))
            bank = ACCESS_HIGH_BANK;
        else
            bank = 4'h0;
        dec.do_clear = (word[15:OP7_LSB] == CLEAR_OPCODE);
        dec.do_invert = (word[15:OP6_LSB] == INVERT_OPCODE);
        dec.do_watchdog = (word == WATCHDOG_WORD);
        dec.to_working = ~word[DEST_BIT];
        dec.address = {bank, word[7:0]};
    end
endmodule : instr_decode
`default_nettype wire

// >>> hdl/clear_complement_wdt_exec.sv
// Execute unit for clear, invert and watchdog restart with APB access
`timescale 1ns/1ps
`default_nettype none
module clear_complement_wdt_exec
    import clear_complement_pkg::*;
#(
    parameter int MEM_WORDS = 4096,
    parameter int WATCHDOG_WIDTH = 8,
    parameter int POSTSCALE_WIDTH = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic watchdog_tick,
    output logic [7:0] working_register,
    output logic [7:0] status_flags
);
    logic [7:0] mem [MEM_WORDS];
    logic [7:0] bank_select_register;
    logic [WATCHDOG_WIDTH-1:0] watchdog_counter;
    logic [POSTSCALE_WIDTH-1:0] postscaler;
    logic [11:0] mem_pointer;
    logic [15:0] exec_count;
    logic [15:0] last_word;
    logic exec_strobe;
    logic wr;
    logic rd_ok;
    decode_type dec;
    logic [7:0] operand;
    logic [7:0] inverted;

    assign wr = psel && penable && pwrite;
    // Instructions issue by writing the instruction register: one per access
    assign exec_strobe = wr && (paddr == OFF_INSTR);
    assign pready = 1'b1;

    instr_decode u_decode (
        .word(pwdata[15:0]),
        .bank_select_register(bank_select_register),
        .dec(dec)
    );

    assign operand = mem[dec.address];
    assign inverted = ~operand;

    always_ff @(posedge pclk)
    begin
        // Memory has no reset so it maps to plain storage
        if (exec_strobe && dec.do_clear)
            mem[dec.address] <= 8'h00;
        else if (exec_strobe && dec.do_invert && !dec.to_working)
            mem[dec.address] <= inverted;
        else if (wr && paddr == OFF_MEM_DATA)
            mem[mem_pointer] <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            working_register <= WORKING_RESET;
        else if (exec_strobe && dec.do_invert && dec.to_working)
            working_register <= inverted;
        else if (wr && paddr == OFF_WORKING)
            working_register <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_flags <= STATUS_RESET;
        else if (exec_strobe && dec.do_clear)
            status_flags[STATUS_Z] <= 1'b1;
        else if (exec_strobe && dec.do_invert)
        begin
            status_flags[STATUS_N] <= inverted[7];
            status_flags[STATUS_Z] <= (inverted == 8'h00);
        end
        else if (exec_strobe && dec.do_watchdog)
        begin
            status_flags[STATUS_TO] <= 1'b1;
            status_flags[STATUS_PD] <= 1'b1;
        end
        else if (wr && paddr == OFF_STATUS)
            status_flags <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bank_select_register <= BANK_RESET;
        else if (wr && paddr == OFF_BANK)
            bank_select_register <= pwdata[7:0];
    end

    // Restart wins over a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog_counter <= '0;
            postscaler <= '0;
        end
        else if (exec_strobe && dec.do_watchdog)
        begin
            watchdog_counter <= '0;
            postscaler <= '0;
        end
        else if (watchdog_tick)
        begin
            postscaler <= postscaler + 1'b1;
            if (&postscaler)
                watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_pointer <= 12'h000;
            exec_count <= 16'h0000;
            last_word <= 16'h0000;
        end
        else
        begin
            if (wr && paddr == OFF_MEM_ADDR)
                mem_pointer <= pwdata[11:0];
            if (exec_strobe)
            begin
                exec_count <= exec_count + 1'b1;
                last_word <= pwdata[15:0];
            end
        end
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (paddr)
            OFF_INSTR: prdata = {16'h0000, last_word};
            OFF_WORKING: prdata = {24'h00_0000, working_register};
            OFF_BANK: prdata = {24'h00_0000, bank_select_register};
            OFF_STATUS: prdata = {24'h00_0000, status_flags};
            OFF_WATCHDOG: prdata = {16'h0000,
                8'(postscaler), 8'(watchdog_counter)};
            OFF_MEM_ADDR: prdata = {20'h0_0000, mem_pointer};
            OFF_MEM_DATA: prdata = {24'h00_0000, mem[mem_pointer]};
            OFF_COUNT: prdata = {16'h0000, exec_count};
            default: rd_ok = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !rd_ok;

    property p_clear_zero;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_clear |=> status_flags[STATUS_Z];
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear did not set zero flag");

    property p_clear_keeps_n;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_clear |=> $stable(status_flags[STATUS_N]);
    endproperty
    a_clear_keeps_n: assert property (p_clear_keeps_n)
        else $error("clear changed negative flag");

    property p_clear_mem;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_clear |=> mem[$past(dec.address)] == 8'h00;
    endproperty
    a_clear_mem: assert property (p_clear_mem)
        else $error("clear did not zero register");

    property p_invert_f;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_invert && !dec.to_working
            |=> mem[$past(dec.address)] == ~$past(operand);
    endproperty
    a_invert_f: assert property (p_invert_f)
        else $error("invert to source register wrong");

    property p_wdt_restart;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_watchdog
            |=> watchdog_counter == '0 && postscaler == '0;
    endproperty
    a_wdt_restart: assert property (p_wdt_restart)
        else $error("watchdog restart did not zero counters");

    property p_wdt_flags;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_watchdog
            |=> status_flags[STATUS_TO] && status_flags[STATUS_PD]
                && $stable(status_flags[STATUS_Z]);
    endproperty
    a_wdt_flags: assert property (p_wdt_flags)
        else $error("watchdog restart flags wrong");

    property p_invert_w;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_invert && dec.to_working
            |=> working_register == ~$past(operand);
    endproperty
    a_invert_w: assert property (p_invert_w)
        else $error("invert to working register wrong");

    property p_invert_flags;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && dec.do_invert
            |=> status_flags[STATUS_Z] == ($past(operand) == 8'hff)
                && status_flags[STATUS_N] == ~$past(operand[7]);
    endproperty
    a_invert_flags: assert property (p_invert_flags)
        else $error("invert flags wrong");

    property p_bank_access;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && !pwdata[ACCESS_BIT] && !pwdata[7]
            |-> dec.address[11:8] == 4'h0;
    endproperty
    a_bank_access: assert property (p_bank_access)
        else $error("access bank not selected");

    property p_bank_bsr;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe && pwdata[ACCESS_BIT]
            |-> dec.address[11:8] == bank_select_register[3:0];
    endproperty
    a_bank_bsr: assert property (p_bank_bsr)
        else $error("bank select not used");

    property p_count;
        @(posedge pclk) disable iff (!presetn)
        exec_strobe |=> exec_count == $past(exec_count) + 16'h0001;
    endproperty
    a_count: assert property (p_count)
        else $error("instruction count wrong");
endmodule : clear_complement_wdt_exec
`default_nettype wire

// >>> bench/tb_clear_complement_wdt_exec.sv
// Self-checking bench for the clear, invert and watchdog restart unit
`timescale 1ns/1ps
`default_nettype none
module tb_clear_complement_wdt_exec
    import clear_complement_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic watchdog_tick = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] working_register;
    logic [7:0] status_flags;
    logic [15:0] lfsr_state = 16'h001d;
    int err_count = 0;
    int num_checks = 0;

    clear_complement_wdt_exec dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_tick(watchdog_tick),
        .working_register(working_register), .status_flags(status_flags));

    always #2 pclk = ~pclk;

    function logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    function logic [11:0] mem_addr(input logic a, input logic [7:0] f,
                                   input logic [7:0] b);
        if (a)
            return {b[3:0], f};
        return f < 8'h80 ? {4'h0, f} : {4'hf, f};
    endfunction : mem_addr

    task print_verdict;
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task check(input string nm, input logic [31:0] exp,
               input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check("pready", 32'h0000_0001, {31'h0, pready});
        // Taken at the edge that completes the access, before it updates
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(nm, exp, q);
    endtask : rdc

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        logic [31:0] q;
        logic e;
        logic [15:0] r;
        logic [15:0] r2;
        logic [7:0] f, v, w, s, b, res, em, ew, est;
        logic a, d;
        logic [11:0] ad;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc("status reset", OFF_STATUS, 32'h0000_0003);
        rdc("working reset", OFF_WORKING, 32'h0000_0000);
        for (int i = 0; i < 8; i++)
        begin
            lfsr_state = next_rand(lfsr_state);
            r = lfsr_state;
            lfsr_state = next_rand(lfsr_state);
            r2 = lfsr_state;
            {f, v} = r;
            {a, d, b} = {r2[0], r2[1], r2[7:0]};
            w = r[7:0] ^ r2[15:8];
            s = r2[15:8] & 8'h17;
            if (i == 0) v = 8'hff;
            if (i == 1) v = 8'h00;
            if (i == 2) {a, f} = {1'b0, 8'h7f};
            if (i == 3) {a, f} = {1'b0, 8'h80};
            ad = mem_addr(a, f, b);
            res = ~v;
            em = d ? res : v;
            ew = d ? w : res;
            est = {3'h0, res[7], 1'b0, res == 8'h00, s[1:0]};
            wr(OFF_BANK, {24'h0, b});
            wr(OFF_MEM_ADDR, {20'h0, ad});
            wr(OFF_MEM_DATA, {24'h0, v});
            wr(OFF_WORKING, {24'h0, w});
            wr(OFF_STATUS, {24'h0, s});
            wr(OFF_INSTR, {16'h0, INVERT_OPCODE, d, a, f});
            rdc("invert mem", OFF_MEM_DATA, {24'h0, em});
            rdc("invert working", OFF_WORKING, {24'h0, ew});
            check("working port", 32'(ew), 32'(working_register));
            rdc("invert status", OFF_STATUS, {24'h0, est});
            wr(OFF_INSTR, {16'h0, CLEAR_OPCODE, a, f});
            rdc("clear mem", OFF_MEM_DATA, 32'h0000_0000);
            // Clear only raises zero; negative stays from the invert
            est[2] = 1'b1;
            rdc("clear status", OFF_STATUS, {24'h0, est});
        end
        // Enough ticks to wrap the postscaler once, so the counter is not 0
        repeat (261) @(posedge pclk) watchdog_tick <= 1'b1;
        @(posedge pclk) watchdog_tick <= 1'b0;
        rdc("postscaler", OFF_WATCHDOG, 32'h0000_0501);
        wr(OFF_STATUS, 32'h0000_0014);
        wr(OFF_INSTR, {16'h0, WATCHDOG_WORD});
        rdc("watchdog restart", OFF_WATCHDOG, 32'h0000_0000);
        rdc("restart status", OFF_STATUS, 32'h0000_0017);
        check("status port", 32'h0000_0017, {24'h0, status_flags});
        wr(OFF_INSTR, 32'h0000_ffff);
        rdc("instr count", OFF_COUNT, 32'h0000_0012);
        apb(1'b0, 12'h020, 32'h0000_0000, q, e);
        check("unmapped err", 32'h0000_0001, {31'h0, e});
        check("unmapped data", 32'h0000_0000, q);
        print_verdict();
    end
endmodule : tb_clear_complement_wdt_exec
`default_nettype wire
